//--- logic/pstab_pkg.sv
// package for the program space table access datapath
// assumes a 24-bit program word array and a 16-bit data bus on one clock
package pstab_pkg;
  localparam int unsigned PSTAB_PWORD_W     = 24;
  localparam int unsigned PSTAB_DATA_W      = 16;
  localparam int unsigned PSTAB_PAGE_W      = 8;
  localparam int unsigned PSTAB_OFFS_W      = 16;
  localparam int unsigned PSTAB_CFG_BIT     = 7;   // page bit that picks config space
  localparam int unsigned PSTAB_BSEL_BIT    = 0;   // address bit that picks the byte
  localparam int unsigned PSTAB_WORD_LSB    = 1;   // word index starts above byte select
  localparam logic [7:0]  PSTAB_PAGE_RST    = 8'h00;
  localparam logic [7:0]  PSTAB_ZERO_BYTE   = 8'h00;

  // table operation codes
  typedef enum logic [1:0] {
    PSTAB_OP_READ_LOW   = 2'h0,
    PSTAB_OP_READ_HIGH  = 2'h1,
    PSTAB_OP_WRITE_LOW  = 2'h2,
    PSTAB_OP_WRITE_HIGH = 2'h3
  } pstab_op_e;

  // request from the execute stage
  typedef struct packed {
    pstab_op_e   op;
    logic        byte_mode;
    logic [15:0] offset;
    logic [15:0] wdata;
  } pstab_req_s;

  // access toward the flash array
  typedef struct packed {
    logic        cfg_space;
    logic [22:0] word_addr;
    logic [23:0] wdata;
    logic [2:0]  byte_en;
  } pstab_mem_s;

  // answer back to the execute stage
  typedef struct packed {
    logic [15:0] rdata;
  } pstab_rsp_s;

  // state of the access sequencer
  typedef enum logic [2:0] {
    PSTAB_ST_IDLE = 3'b001,
    PSTAB_ST_WAIT = 3'b010,
    PSTAB_ST_DONE = 3'b100
  } pstab_state_e;
endpackage

//--- logic/pstab_table_access.sv
// table access datapath between the execute stage and the program flash array
// assumes the array answers a read with o_mem_req held until i_mem_ack for one cycle
//
// Function
// - a word read of the low space returns program bits 15..0 unchanged.
// - a byte read of the low space puts the upper byte when byte select is 1, else the lower.
// - a word read of the high space returns bits 23..16 low with the upper data byte zero.
// - a byte read of the high space returns bits 23..16 on select 0 and zeros on select 1.
// - addresses step by two per program word so both spaces share one address range.
// - the upper address bits of every table access come from the table page register.
// - page bit 7 clear selects user space and set selects configuration space.
// - only high operations reach the upper program byte; low ones reach the lower word.
// - every read and write exists in byte and in word form.
module pstab_table_access
  import pstab_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  input  wire logic               i_page_we,
  input  wire logic [7:0]         i_page_wdata,
  output logic      [7:0]         o_table_page_register,
  input  wire logic               i_req_valid,
  input  wire pstab_req_s         i_req,
  output logic                    o_req_ready,
  output logic                    o_rsp_valid,
  output pstab_rsp_s              o_rsp,
  output logic                    o_mem_req,
  output logic                    o_mem_we,
  output pstab_mem_s              o_mem,
  input  wire logic               i_mem_ack,
  input  wire logic [23:0]        i_mem_rdata
);

  pstab_state_e state_ff, nxt_state;
  logic [7:0]   page_ff;
  pstab_req_s   req_ff;
  pstab_mem_s   mem_ff, nxt_mem;
  logic [15:0]  rdata_ff, nxt_rdata;
  logic         rsp_ff;

  // shape a 24-bit program word into a 16-bit data answer
  function automatic logic [15:0] read_shape(input pstab_op_e op, input logic bmode,
                                              input logic bsel, input logic [23:0] pw);
    logic [15:0] r;
    r = 16'h0000;
    if (op == PSTAB_OP_READ_HIGH) begin
      if (!bmode) r = {PSTAB_ZERO_BYTE, pw[23:16]};
      else if (!bsel) r = {PSTAB_ZERO_BYTE, pw[23:16]};
      else r = 16'h0000;                                         // phantom byte
    end else begin
      if (!bmode) r = pw[15:0];
      else if (bsel) r = {PSTAB_ZERO_BYTE, pw[15:8]};
      else r = {PSTAB_ZERO_BYTE, pw[7:0]};
    end
    return r;
  endfunction

  // address, space and lane decode of the incoming request
  wire logic        acc_take  = i_req_valid && (state_ff == PSTAB_ST_IDLE);
  wire logic        req_bsel  = i_req.offset[PSTAB_BSEL_BIT];
  wire logic        req_high  = (i_req.op == PSTAB_OP_READ_HIGH) ||
                                (i_req.op == PSTAB_OP_WRITE_HIGH);
  wire logic        req_write = (i_req.op == PSTAB_OP_WRITE_LOW) ||
                                (i_req.op == PSTAB_OP_WRITE_HIGH);
  // word index: page above, offset without byte select below; two per word
  wire logic [22:0] req_waddr = {page_ff, i_req.offset[15:PSTAB_WORD_LSB]};
  wire logic        req_cfg   = page_ff[PSTAB_CFG_BIT];
  // lane enables: high ops touch only byte 2, low ops bytes 1..0
  wire logic [2:0]  req_ben   = req_high ? (i_req.byte_mode && req_bsel ? 3'h0 : 3'h4)
                                : (!i_req.byte_mode ? 3'h3 : (req_bsel ? 3'h2 : 3'h1));
  wire logic [23:0] req_wdat  = req_high ? {i_req.wdata[7:0], 16'h0000}
                                : (i_req.byte_mode && req_bsel
                                   ? {8'h00, i_req.wdata[7:0], 8'h00}
                                   : {8'h00, i_req.wdata});

  assign o_req_ready = (state_ff == PSTAB_ST_IDLE);
  assign o_table_page_register = page_ff;
  assign o_mem_req = (state_ff == PSTAB_ST_WAIT);
  assign o_mem_we  = (state_ff == PSTAB_ST_WAIT) &&
                     ((req_ff.op == PSTAB_OP_WRITE_LOW) || (req_ff.op == PSTAB_OP_WRITE_HIGH));
  assign o_mem     = mem_ff;
  assign o_rsp_valid = rsp_ff;
  assign o_rsp.rdata = rdata_ff;

  // sequencer: idle, wait for the array, one answer cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_mem   = mem_ff;
    nxt_rdata = rdata_ff;
    case (state_ff)
      PSTAB_ST_IDLE: begin
        if (acc_take) begin
          nxt_state = PSTAB_ST_WAIT;
          nxt_mem   = '{cfg_space: req_cfg, word_addr: req_waddr,
                        wdata: req_wdat, byte_en: req_write ? req_ben : 3'h0};
        end
      end
      PSTAB_ST_WAIT: begin
        if (i_mem_ack) begin
          nxt_state = PSTAB_ST_DONE;
          nxt_rdata = read_shape(req_ff.op, req_ff.byte_mode,
                                 req_ff.offset[PSTAB_BSEL_BIT], i_mem_rdata);
        end
      end
      PSTAB_ST_DONE: nxt_state = PSTAB_ST_IDLE;
      default:       nxt_state = PSTAB_ST_IDLE;
    endcase
  end

  // page register; a page write while an access is queued waits no cycle
  always_ff @(posedge i_clk) begin
    if (i_reset) page_ff <= PSTAB_PAGE_RST;
    else if (i_page_we) page_ff <= i_page_wdata;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_ff <= PSTAB_ST_IDLE;
      mem_ff   <= '0;
      rdata_ff <= 16'h0000;
      req_ff   <= '0;
      rsp_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      mem_ff   <= nxt_mem;
      rdata_ff <= nxt_rdata;
      rsp_ff   <= (state_ff == PSTAB_ST_WAIT) && i_mem_ack;
      if (acc_take) req_ff <= i_req;
    end
  end

  // checks on the datapath
  property p_low_word;
    @(posedge i_clk) disable iff (i_reset)
      (o_mem_req && i_mem_ack && req_ff.op == PSTAB_OP_READ_LOW && !req_ff.byte_mode)
      |=> (o_rsp.rdata == $past(i_mem_rdata[15:0]));
  endproperty
  a_low_word: assert property (p_low_word) else $error("low word read wrong");

  property p_low_byte;
    @(posedge i_clk) disable iff (i_reset)
      (o_mem_req && i_mem_ack && req_ff.op == PSTAB_OP_READ_LOW && req_ff.byte_mode)
      |=> (o_rsp.rdata[7:0] == ($past(req_ff.offset[0]) ? $past(i_mem_rdata[15:8])
                                                        : $past(i_mem_rdata[7:0])))
          && (o_rsp.rdata[15:8] == 8'h00);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte read wrong");

  property p_high_word;
    @(posedge i_clk) disable iff (i_reset)
      (o_mem_req && i_mem_ack && req_ff.op == PSTAB_OP_READ_HIGH && !req_ff.byte_mode)
      |=> (o_rsp.rdata == {8'h00, $past(i_mem_rdata[23:16])});
  endproperty
  a_high_word: assert property (p_high_word) else $error("high word read wrong");

  property p_high_byte;
    @(posedge i_clk) disable iff (i_reset)
      (o_mem_req && i_mem_ack && req_ff.op == PSTAB_OP_READ_HIGH && req_ff.byte_mode)
      |=> (o_rsp.rdata == ($past(req_ff.offset[0]) ? 16'h0000
                                                   : {8'h00, $past(i_mem_rdata[23:16])}));
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("high byte read wrong");

  property p_addr;
    @(posedge i_clk) disable iff (i_reset)
      acc_take |=> (o_mem.word_addr == {$past(page_ff), $past(i_req.offset[15:1])});
  endproperty
  a_addr: assert property (p_addr) else $error("word address wrong");

  property p_page;
    @(posedge i_clk) disable iff (i_reset)
      acc_take |=> (o_mem.word_addr[22:15] == $past(o_table_page_register));
  endproperty
  a_page: assert property (p_page) else $error("page not used");

  property p_space;
    @(posedge i_clk) disable iff (i_reset)
      acc_take |=> o_mem_req && (o_mem.cfg_space == $past(page_ff[7]));
  endproperty
  a_space: assert property (p_space) else $error("space select wrong");

  property p_lanes;
    @(posedge i_clk) disable iff (i_reset)
      o_mem_we |-> ((req_ff.op == PSTAB_OP_WRITE_HIGH) ? (o_mem.byte_en[1:0] == 2'h0)
                                                       : (o_mem.byte_en[2] == 1'b0));
  endproperty
  a_lanes: assert property (p_lanes) else $error("write lane crosses space");

  property p_wbyte;
    @(posedge i_clk) disable iff (i_reset)
      (o_mem_we && req_ff.op == PSTAB_OP_WRITE_LOW && req_ff.byte_mode)
      |-> (o_mem.byte_en == (req_ff.offset[0] ? 3'h2 : 3'h1));
  endproperty
  a_wbyte: assert property (p_wbyte) else $error("byte write lane wrong");

  // a read must never open a lane, or a stray word would be programmed
  property p_read_lanes;
    @(posedge i_clk) disable iff (i_reset)
      (o_mem_req && !o_mem_we) |-> (o_mem.byte_en == 3'h0);
  endproperty
  a_read_lanes: assert property (p_read_lanes) else $error("read drives lanes");

  property p_low_wdata;
    @(posedge i_clk) disable iff (i_reset)
      (o_mem_we && req_ff.op == PSTAB_OP_WRITE_LOW && !req_ff.byte_mode)
      |-> (o_mem.wdata[15:0] == req_ff.wdata) && (o_mem.byte_en == 3'h3);
  endproperty
  a_low_wdata: assert property (p_low_wdata) else $error("low write data wrong");

  // the high byte travels in data bits 7..0 and lands in program bits 23..16
  property p_high_wdata;
    @(posedge i_clk) disable iff (i_reset)
      (o_mem_we && req_ff.op == PSTAB_OP_WRITE_HIGH && o_mem.byte_en[2])
      |-> (o_mem.wdata[23:16] == req_ff.wdata[7:0]);
  endproperty
  a_high_wdata: assert property (p_high_wdata) else $error("high write data wrong");

  c_read_high: cover property (@(posedge i_clk) disable iff (i_reset)
    acc_take && i_req.op == PSTAB_OP_READ_HIGH ##[1:20] o_rsp_valid);
  c_read_low_byte: cover property (@(posedge i_clk) disable iff (i_reset)
    acc_take && i_req.op == PSTAB_OP_READ_LOW && i_req.byte_mode ##[1:20] o_rsp_valid);
  c_write_cfg: cover property (@(posedge i_clk) disable iff (i_reset)
    o_mem_we && o_mem.cfg_space);
  c_write_high_byte: cover property (@(posedge i_clk) disable iff (i_reset)
    o_mem_we && o_mem.byte_en == 3'h4 && req_ff.byte_mode);
  c_read_cfg: cover property (@(posedge i_clk) disable iff (i_reset)
    o_mem_req && !o_mem_we && o_mem.cfg_space);
endmodule

//--- verif/pstab_flash_model.sv
// program flash array model for the table access datapath
// assumes o_mem stands from the request until the acknowledge edge
module pstab_flash_model
  import pstab_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_mem_req,
  input  wire pstab_mem_s  i_mem,
  input  wire logic [3:0]  i_delay,
  output logic             o_ack,
  output logic [23:0]      o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] mem [logic [23:0]];
  logic [3:0]  cnt;
  logic [23:0] key;
  logic [23:0] w;
  initial begin
    o_ack = 1'b0;
    o_rdata = 24'h000000;
    cnt = 4'h0;
  end
  assign key = {i_mem.cfg_space, i_mem.word_addr};
  // blank words hold an address pattern; rdata flips when not answering
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_mem_req && !o_ack) begin
      if (cnt != i_delay) begin
        cnt <= cnt + 4'h1;
      end else begin
        cnt <= 4'h0;
        w = mem.exists(key) ? mem[key] : key ^ 24'h5A3C96;
        for (int i = 0; i < 3; i++) if (i_mem.byte_en[i]) w[8*i+:8] = i_mem.wdata[8*i+:8];
        mem[key] = w;
        o_ack <= 1'b1;
        o_rdata <= w;
      end
    end
  end
endmodule

//--- verif/tb.sv
// testbench for the table access datapath with a flash array model
// assumes one access at a time, inputs driven 1 ns after each rising edge
module tb
  import pstab_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, page_we, req_valid, ready, rsp_valid, mem_req, mem_we, ack;
  logic [7:0]  page_wd, page, pg;
  logic [3:0]  dly;
  logic [23:0] rd;
  pstab_req_s  req;
  pstab_rsp_s  rsp;
  pstab_mem_s  mem;
  int bad_count, n_compared, cycles;

  pstab_table_access dut (.i_clk(clk), .i_reset(rst), .i_page_we(page_we),
    .i_page_wdata(page_wd), .o_table_page_register(page), .i_req_valid(req_valid),
    .i_req(req), .o_req_ready(ready), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
    .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem(mem), .i_mem_ack(ack),
    .i_mem_rdata(rd));
  pstab_flash_model flash (.i_clk(clk), .i_mem_req(mem_req), .i_mem(mem),
    .i_delay(dly), .o_ack(ack), .o_rdata(rd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic set_page(input logic [7:0] p);
    page_we = 1'b1;
    page_wd = p;
    pg = p;
    @(posedge clk);
    #1 page_we = 1'b0;
    chk("page", p, page);
  endtask

  // one access: checks array address and lanes, leaves ready back high
  task automatic run(input pstab_op_e op, input logic bm, input logic [15:0] off,
                     input logic [15:0] wd, input logic [2:0] be);
    int n;
    chk("ready", 1, ready);
    req = '{op, bm, off, wd};
    req_valid = 1'b1;
    @(posedge clk);
    #1 req_valid = 1'b0;
    chk("mem_addr", {pg[7], pg, off[15:1]}, {mem.cfg_space, mem.word_addr});
    chk("mem_ctl", {1'b1, (op == PSTAB_OP_WRITE_LOW || op == PSTAB_OP_WRITE_HIGH), be},
        {mem_req, mem_we, mem.byte_en});
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk("rsp_valid", 1, rsp_valid);
    @(posedge clk);
    #1;
    chk("rsp_once", 2'b01, {rsp_valid, ready});
  endtask

  // every read form, both pages kinds, both byte selects, prompt and slow array
  task automatic t_reads();
    logic [23:0] w;
    logic [15:0] off, e, m;
    for (int s = 0; s < 2; s++) begin
      set_page(s ? 8'h81 : 8'h01);
      for (int k = 0; k < 8; k++) begin
        dly = k[0] ? 4'h3 : 4'h0;
        off = 16'h4A10 + 16'(k[0]) + 16'(4 * k);
        w = {pg[7], pg, off[15:1]} ^ 24'h5A3C96;
        run(k[2] ? PSTAB_OP_READ_HIGH : PSTAB_OP_READ_LOW, k[1], off, 16'h0000, 3'h0);
        if (!k[2]) e = k[1] ? {8'h00, k[0] ? w[15:8] : w[7:0]} : w[15:0];
        else e = (k[1] && k[0]) ? 16'h0000 : {8'h00, w[23:16]};
        m = (k[1] && !(k[2] && k[0])) ? 16'h00FF : 16'hFFFF;
        chk("rdata", e & m, rsp.rdata & m);
      end
    end
  endtask

  // every write form, then the word read back in both halves
  task automatic t_writes();
    set_page(8'h02);
    dly = 4'h1;
    run(PSTAB_OP_WRITE_LOW, 1'b0, 16'h0100, 16'hBEEF, 3'h3);
    run(PSTAB_OP_WRITE_LOW, 1'b1, 16'h0101, 16'h0077, 3'h2);
    run(PSTAB_OP_WRITE_HIGH, 1'b0, 16'h0100, 16'h00C5, 3'h4);
    run(PSTAB_OP_WRITE_HIGH, 1'b1, 16'h0100, 16'h00D2, 3'h4);
    run(PSTAB_OP_WRITE_HIGH, 1'b1, 16'h0101, 16'h0033, 3'h0);
    run(PSTAB_OP_READ_LOW, 1'b0, 16'h0100, 16'h0000, 3'h0);
    chk("low_back", 16'h77EF, rsp.rdata);
    run(PSTAB_OP_READ_HIGH, 1'b0, 16'h0100, 16'h0000, 3'h0);
    chk("high_back", 16'h00D2, rsp.rdata);
  endtask

  // reset in mid-run: page back to zero, first access at the first edge after release
  task automatic t_reset();
    set_page(8'h85);
    rst = 1'b1;
    @(posedge clk);
    @(posedge clk);
    #1 rst = 1'b0;
    chk("reset2", {1'b1, 8'h00, 2'b00}, {ready, page, mem_req, rsp_valid});
    pg = 8'h00;
    dly = 4'h0;
    run(PSTAB_OP_READ_LOW, 1'b0, 16'h0020, 16'h0000, 3'h0);
    chk("rdata_rst", 16'h3C86, rsp.rdata);
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well above the roughly 140 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    rst = 1'b1;
    page_we = 1'b0;
    page_wd = 8'h00;
    req_valid = 1'b0;
    req = '0;
    dly = 4'h0;
    pg = 8'h00;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    chk("reset", {1'b1, 8'h00, 2'b00}, {ready, page, mem_req, rsp_valid});
    t_reads();
    t_writes();
    t_reset();
    summarize();
  end
endmodule
